// [logic/pea_pkg.sv]
// Shared constants and types for the page-mode EPROM access controller
package pea_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W        = 18;
  localparam int BADDR_W       = 19;
  localparam int DATA_W        = 16;
  localparam int LOW_W         = 15;
  localparam int BYTE_W        = 8;
  localparam int PAGE_LSB      = 3;
  localparam int TMR_W         = 16;
  localparam int PULSE_CNT_W   = 5;
  localparam int ID_PARITY_BIT = 15;

  // ****************************************************************
  // Timing, in nanoseconds, microseconds and derived clock cycles
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 8;
  localparam int SYNC_CYC          = 2;
  localparam int FULL_ACCESS_NS    = 150;
  localparam int PAGE_ACCESS_NS    = 75;
  localparam int SETTLE_NS         = 100;
  localparam int PROG_PULSE_US     = 100;
  localparam int MAX_PULSES        = 25;
  localparam int FULL_ACCESS_CYC   = (FULL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_ACCESS_CYC   = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC        = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_PULSE_CYC    = (PROG_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Commands
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_READ_WORD,
    OP_READ_BYTE,
    OP_READ_ID,
    OP_PROGRAM
  } pea_op_t;

endpackage : pea_pkg

// [logic/pea_timer.sv]
// Down-counting wait timer used for every access and pulse delay
module pea_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              zero
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Load wins, otherwise count down to zero and rest
  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = value;
    else if (cnt_q != '0)
      cnt_d = cnt_q - W'(1);
  end

  // Count register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  // Taken from the register alone so that load may depend on it
  assign zero = (cnt_q == '0);

endmodule : pea_timer

// [logic/pea_host.sv]
// Host controller that reads and programs a page-mode EPROM through its pins
// Contract
// [R1] Erased cells read one; programming clears bits
// [R2] Program word driven on all sixteen lines
// [R3] Program supply raised while output enable high
// [R4] One 100 us chip-select pulse after settling
// [R5] Retry on verify mismatch, 25 pulses at most
// [R6] Program every address, then verify at normal supply
// [R7] Chip select high inhibits programming
// [R8] Verify: output enable low, chip select high
// [R9] Identifier: high voltage, lowest bit selects code
// [R10] Identifier words carry odd parity in bit 15
// [R11] Eight-word pages give faster page access
// [R12] Page hit: chip select low, low bits change
// [R13] Word width drives all sixteen data lines
// [R14] Byte width: top pin selects byte
// [R15] Chip select high floats all outputs
// [R16] Outputs drive only with both enables low
// [R17] Chip select decoded, output enable shared strobe
// [R18] Identifier readout holds other address lines low
// [R19] Data stable only after access delay elapses
module pea_host #(
  parameter int PROG_PULSE_CYC = pea_pkg::PROG_PULSE_CYC,
  parameter int MAX_PULSES     = pea_pkg::MAX_PULSES
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         cmd_valid,
  output logic                              cmd_ready,
  input  wire pea_pkg::pea_op_t             cmd_op,
  input  wire logic [pea_pkg::BADDR_W-1:0]  cmd_addr,
  input  wire logic [pea_pkg::ADDR_W-1:0]   cmd_end,
  output logic                              data_req,
  output logic [pea_pkg::ADDR_W-1:0]        data_req_addr,
  input  wire logic [pea_pkg::DATA_W-1:0]   wdata,
  output logic                              rsp_valid,
  output logic [pea_pkg::DATA_W-1:0]        rsp_data,
  output logic                              rsp_ok,
  output logic [pea_pkg::ADDR_W-1:0]        rsp_fail_addr,
  output logic [pea_pkg::ADDR_W-1:0]        address_lines,
  output logic                              ce_n,
  output logic                              oe_n,
  output logic                              byte_n,
  output logic                              vpp_en,
  output logic                              id_high_voltage_en,
  output logic [pea_pkg::LOW_W-1:0]         data_lines_o,
  output logic                              data_lines_oe_n,
  input  wire logic [pea_pkg::LOW_W-1:0]    data_lines_i,
  output logic                              top_data_or_byte_select_o,
  output logic                              top_data_or_byte_select_oe_n,
  input  wire logic                         top_data_or_byte_select_i
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_RD_WAIT, S_PG_REQ, S_PG_LOAD, S_PG_DRIVE, S_PG_SETUP,
    S_PG_PULSE, S_PG_HOLD, S_PG_VWAIT, S_VF_REQ, S_VF_LOAD, S_VF_WAIT
  } pea_state_t;

  localparam int AW = pea_pkg::ADDR_W;
  localparam int DW = pea_pkg::DATA_W;
  localparam int TW = pea_pkg::TMR_W;
  localparam int PW = pea_pkg::PULSE_CNT_W;

  pea_state_t     state_q, state_d;
  logic [AW-1:0]  addr_q, addr_d, start_q, start_d, end_q, end_d;
  logic [AW-1:0]  fail_q, fail_d, req_addr_q, req_addr_d;
  logic [DW-1:0]  wd_q, wd_d, rdat_q, rdat_d;
  logic [PW-1:0]  pulses_q, pulses_d;
  logic           ok_q, ok_d, rsp_q, rsp_d, req_q, req_d, rdy_q, rdy_d;
  logic           page_open_q, page_open_d, id_rd_q, id_rd_d, byte_rd_q, byte_rd_d;
  logic [AW-1:0]  pin_addr_q, pin_addr_d;
  logic           ce_n_q, ce_n_d, oe_n_q, oe_n_d, byte_n_q, byte_n_d;
  logic           vpp_q, vpp_d, idhv_q, idhv_d, doe_n_q, doe_n_d;
  logic           top_o_q, top_o_d, top_oe_n_q, top_oe_n_d;
  localparam int LOW_W_C = pea_pkg::LOW_W;
  logic [LOW_W_C-1:0] dout_q, dout_d;
  logic [DW-1:0]  sync1_q, sync2_q;
  logic           tmr_load;
  logic [TW-1:0]  tmr_val;
  logic           tmr_zero;
  logic           hit;
  logic           match;

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  // Two flops on the data pins before any compare
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {top_data_or_byte_select_i, data_lines_i};
      sync2_q <= sync1_q;
    end
  end

  // Shared wait timer
  pea_timer #(.W(TW)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (tmr_load),
    .value (tmr_val),
    .zero  (tmr_zero)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Same page, same width and no identifier keeps the page path
  assign hit = page_open_q && !id_rd_q && (cmd_op != pea_pkg::OP_READ_ID) // see [R11]
               && (byte_rd_q == (cmd_op == pea_pkg::OP_READ_BYTE))
               && (cmd_op == pea_pkg::OP_READ_BYTE
                   && pin_addr_q[AW-1:pea_pkg::PAGE_LSB] == cmd_addr[AW:pea_pkg::PAGE_LSB+1] // see [R12]
                   || cmd_op == pea_pkg::OP_READ_WORD
                   && pin_addr_q[AW-1:pea_pkg::PAGE_LSB] == cmd_addr[AW-1:pea_pkg::PAGE_LSB]);
  assign match = (sync2_q == wd_q);

  // Next-state and pin values
  always_comb
  begin
    state_d = state_q;     addr_d = addr_q;     start_d = start_q;   end_d = end_q;
    fail_d = fail_q;       req_addr_d = req_addr_q; wd_d = wd_q;    rdat_d = rdat_q;
    pulses_d = pulses_q;   ok_d = ok_q;         rsp_d = 1'b0;        req_d = 1'b0;
    page_open_d = page_open_q; id_rd_d = id_rd_q; byte_rd_d = byte_rd_q;
    pin_addr_d = pin_addr_q; ce_n_d = ce_n_q;   oe_n_d = oe_n_q;     byte_n_d = byte_n_q;
    vpp_d = vpp_q;         idhv_d = idhv_q;     doe_n_d = doe_n_q;   dout_d = dout_q;
    top_o_d = top_o_q;     top_oe_n_d = top_oe_n_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_q)
      S_IDLE:
        if (cmd_valid && cmd_op == pea_pkg::OP_PROGRAM)
        begin
          // Deselect and let the device float before driving data
          addr_d = cmd_addr[AW-1:0];  start_d = cmd_addr[AW-1:0];  end_d = cmd_end;
          ok_d = 1'b1;  fail_d = '0;  page_open_d = 1'b0;  idhv_d = 1'b0;
          ce_n_d = 1'b1;  oe_n_d = 1'b1;  byte_n_d = 1'b1;  top_oe_n_d = 1'b1;
          tmr_load = 1'b1;  tmr_val = TW'(pea_pkg::SETTLE_CYC - 1);
          state_d = S_PG_REQ;
        end
        else if (cmd_valid)
        begin
          id_rd_d = (cmd_op == pea_pkg::OP_READ_ID);
          byte_rd_d = (cmd_op == pea_pkg::OP_READ_BYTE);
          idhv_d = (cmd_op == pea_pkg::OP_READ_ID);                           // see [R9]
          byte_n_d = (cmd_op != pea_pkg::OP_READ_BYTE);
          ce_n_d = 1'b0;  oe_n_d = 1'b0;  doe_n_d = 1'b1;                    // see [R16]
          vpp_d = 1'b0;
          if (cmd_op == pea_pkg::OP_READ_ID)
          begin
            pin_addr_d = AW'(cmd_addr[0]);                                    // see [R18]
            top_oe_n_d = 1'b1;
          end
          else if (cmd_op == pea_pkg::OP_READ_BYTE)
          begin
            pin_addr_d = cmd_addr[AW:1];
            top_o_d = cmd_addr[0];                                            // see [R14]
            top_oe_n_d = 1'b0;
          end
          else
          begin
            pin_addr_d = cmd_addr[AW-1:0];
            top_oe_n_d = 1'b1;                                                // see [R13]
          end
          tmr_load = 1'b1;                                                    // see [R19]
          tmr_val = hit ? TW'(pea_pkg::PAGE_ACCESS_CYC + pea_pkg::SYNC_CYC - 1)
                        : TW'(pea_pkg::FULL_ACCESS_CYC + pea_pkg::SYNC_CYC - 1);
          state_d = S_RD_WAIT;
        end
      S_RD_WAIT:
        if (tmr_zero)
        begin
          // Chip select stays low so the next read may hit the page
          rdat_d = byte_rd_q ? {{pea_pkg::BYTE_W{1'b0}}, sync2_q[pea_pkg::BYTE_W-1:0]} : sync2_q;
          ok_d = id_rd_q ? (^sync2_q) : 1'b1;                                 // see [R10]
          page_open_d = !id_rd_q;
          rsp_d = 1'b1;
          state_d = S_IDLE;
        end
      S_PG_REQ:
        if (tmr_zero)
        begin
          req_d = 1'b1;
          req_addr_d = addr_q;
          state_d = S_PG_LOAD;
        end
      S_PG_LOAD:
      begin
        wd_d = wdata;
        pulses_d = '0;
        state_d = S_PG_DRIVE;
      end
      S_PG_DRIVE:
        if (tmr_zero)
        begin
          // Address and full word settle before the pulse
          pin_addr_d = addr_q;
          dout_d = wd_q[LOW_W_C-1:0];  doe_n_d = 1'b0;                       // see [R2]
          top_o_d = wd_q[DW-1];  top_oe_n_d = 1'b0;
          oe_n_d = 1'b1;
          vpp_d = 1'b1;                                                       // see [R3]
          tmr_load = 1'b1;  tmr_val = TW'(pea_pkg::SETTLE_CYC - 1);
          state_d = S_PG_SETUP;
        end
      S_PG_SETUP:
        if (tmr_zero)
        begin
          ce_n_d = 1'b0;                                                      // see [R4]
          pulses_d = pulses_q + PW'(1);
          tmr_load = 1'b1;  tmr_val = TW'(PROG_PULSE_CYC - 1);
          state_d = S_PG_PULSE;
        end
      S_PG_PULSE:
        if (tmr_zero)
        begin
          ce_n_d = 1'b1;                                                      // see [R7]
          tmr_load = 1'b1;  tmr_val = TW'(pea_pkg::SETTLE_CYC - 1);
          state_d = S_PG_HOLD;
        end
      S_PG_HOLD:
        if (tmr_zero)
        begin
          // Release the bus, then verify with chip select high
          doe_n_d = 1'b1;  top_oe_n_d = 1'b1;
          oe_n_d = 1'b0;                                                      // see [R8]
          tmr_load = 1'b1;
          tmr_val = TW'(pea_pkg::FULL_ACCESS_CYC + pea_pkg::SYNC_CYC - 1);
          state_d = S_PG_VWAIT;
        end
      S_PG_VWAIT:
        if (tmr_zero)
        begin
          oe_n_d = 1'b1;
          tmr_load = 1'b1;  tmr_val = TW'(pea_pkg::SETTLE_CYC - 1);
          if (!match && pulses_q < PW'(MAX_PULSES))
            state_d = S_PG_DRIVE;                                             // see [R5]
          else
          begin
            if (!match && ok_q)
            begin
              ok_d = 1'b0;
              fail_d = addr_q;
            end
            if (addr_q == end_q)
            begin
              addr_d = start_q;                                               // see [R6]
              vpp_d = 1'b0;
              state_d = S_VF_REQ;
            end
            else
            begin
              addr_d = addr_q + AW'(1);
              state_d = S_PG_REQ;
            end
          end
        end
      S_VF_REQ:
        if (tmr_zero)
        begin
          req_d = 1'b1;  req_addr_d = addr_q;
          pin_addr_d = addr_q;  ce_n_d = 1'b0;  oe_n_d = 1'b0;
          state_d = S_VF_LOAD;
        end
      S_VF_LOAD:
      begin
        wd_d = wdata;
        tmr_load = 1'b1;
        tmr_val = TW'(pea_pkg::FULL_ACCESS_CYC + pea_pkg::SYNC_CYC - 2);
        state_d = S_VF_WAIT;
      end
      S_VF_WAIT:
        if (tmr_zero)
        begin
          if (!match && ok_q)
          begin
            ok_d = 1'b0;
            fail_d = addr_q;
          end
          if (addr_q == end_q)
          begin
            ce_n_d = 1'b1;  oe_n_d = 1'b1;                                    // see [R15]
            rdat_d = sync2_q;
            rsp_d = 1'b1;
            state_d = S_IDLE;
          end
          else
          begin
            addr_d = addr_q + AW'(1);
            state_d = S_VF_REQ;
          end
        end
    endcase
    rdy_d = (state_d == S_IDLE);
  end

  // State and pin registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;  addr_q <= '0;  start_q <= '0;  end_q <= '0;  fail_q <= '0;
      req_addr_q <= '0;   wd_q <= '0;    rdat_q <= '0;   pulses_q <= '0; ok_q <= 1'b0;
      rsp_q <= 1'b0;      req_q <= 1'b0; rdy_q <= 1'b0;  page_open_q <= 1'b0;
      id_rd_q <= 1'b0;    byte_rd_q <= 1'b0; pin_addr_q <= '0;
      ce_n_q <= 1'b1;     oe_n_q <= 1'b1;    byte_n_q <= 1'b1;  vpp_q <= 1'b0;
      idhv_q <= 1'b0;     doe_n_q <= 1'b1;   dout_q <= '0;
      top_o_q <= 1'b0;    top_oe_n_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;  addr_q <= addr_d;  start_q <= start_d;  end_q <= end_d;
      fail_q <= fail_d;    req_addr_q <= req_addr_d; wd_q <= wd_d; rdat_q <= rdat_d;
      pulses_q <= pulses_d; ok_q <= ok_d;     rsp_q <= rsp_d;      req_q <= req_d;
      rdy_q <= rdy_d;      page_open_q <= page_open_d; id_rd_q <= id_rd_d;
      byte_rd_q <= byte_rd_d; pin_addr_q <= pin_addr_d;
      ce_n_q <= ce_n_d;    oe_n_q <= oe_n_d;  byte_n_q <= byte_n_d; vpp_q <= vpp_d;
      idhv_q <= idhv_d;    doe_n_q <= doe_n_d; dout_q <= dout_d;
      top_o_q <= top_o_d;  top_oe_n_q <= top_oe_n_d;
    end
  end

  // Output ports straight from flops
  assign cmd_ready = rdy_q;                 assign data_req = req_q;
  assign data_req_addr = req_addr_q;        assign rsp_valid = rsp_q;
  assign rsp_data = rdat_q;                 assign rsp_ok = ok_q;
  assign rsp_fail_addr = fail_q;            assign address_lines = pin_addr_q;
  assign ce_n = ce_n_q;                     assign oe_n = oe_n_q;  // see [R17]
  assign byte_n = byte_n_q;                 assign vpp_en = vpp_q;
  assign id_high_voltage_en = idhv_q;       assign data_lines_o = dout_q;
  assign data_lines_oe_n = doe_n_q;         assign top_data_or_byte_select_o = top_o_q;
  assign top_data_or_byte_select_oe_n = top_oe_n_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Helper: length of the current program pulse
  logic [TW-1:0] low_cnt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_cnt_q <= '0;
    else if (!ce_n_q && vpp_q)
      low_cnt_q <= low_cnt_q + TW'(1);
    else
      low_cnt_q <= '0;
  end

  AST_PULSE_LEN: assert property (@(posedge clk) disable iff (rst) // see [R4]
    $rose(ce_n_q) && vpp_q |-> low_cnt_q == TW'(PROG_PULSE_CYC))
    else $error("Program pulse length wrong");
  AST_PULSE_STABLE: assert property (@(posedge clk) disable iff (rst) // see [R2]
    !ce_n_q && vpp_q |-> !doe_n_q && !top_oe_n_q && $stable(pin_addr_q) && $stable(dout_q))
    else $error("Address or data moved during pulse");
  AST_VPP_OE_HIGH: assert property (@(posedge clk) disable iff (rst) // see [R3]
    $rose(vpp_q) |-> oe_n_q && ce_n_q)
    else $error("Program supply raised with output enable low");
  AST_PULSE_LIMIT: assert property (@(posedge clk) disable iff (rst) // see [R5]
    pulses_q <= PW'(MAX_PULSES))
    else $error("Too many program pulses");
  AST_VERIFY_CE_HIGH: assert property (@(posedge clk) disable iff (rst) // see [R8]
    vpp_q && !oe_n_q |-> ce_n_q && doe_n_q && top_oe_n_q)
    else $error("Bad program verify setup");
  AST_ID_LINES: assert property (@(posedge clk) disable iff (rst) // see [R18]
    idhv_q |-> pin_addr_q[AW-1:1] == '0 && byte_n_q && !vpp_q)
    else $error("Identifier readout with other lines high");
  AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (rst) // see [R16]
    !oe_n_q |-> doe_n_q)
    else $error("Host drives data while device may drive");
  AST_BYTE_SEL: assert property (@(posedge clk) disable iff (rst) // see [R14]
    !byte_n_q && !ce_n_q |-> !top_oe_n_q)
    else $error("Byte select not driven in byte width");
  AST_RSP_AFTER_WAIT: assert property (@(posedge clk) disable iff (rst) // see [R19]
    cmd_valid && rdy_q && cmd_op != pea_pkg::OP_PROGRAM |-> ##[11:22] rsp_q)
    else $error("Read answer outside access window");

endmodule : pea_host

// [test/pea_eprom_model.sv]
// Behavioural page-mode EPROM that answers the host controller's pins
module pea_eprom_model #(
  parameter int          DLY_NS     = 70,
  parameter logic [15:0] MFR_CODE   = 16'h80aa,  // Arbitrary value, odd parity
  parameter logic [15:0] DEV_CODE   = 16'h8e07,  // Arbitrary value, odd parity
  parameter logic [17:0] STUCK_ADDR = 18'h00201
) (
  input  wire logic [17:0] address_lines,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        byte_n,
  input  wire logic        vpp_en,
  input  wire logic        id_hv,
  input  wire logic [15:0] host_word,
  input  wire logic        host_lo_oe_n,
  output logic      [15:0] q,
  output logic             contention,
  output logic             id_addr_bad,
  output int               pulse_ns
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [int];
  int          npulse [int];
  logic [15:0] word_v, out_v, en_v, out_d, en_d, en_p;
  time         t_fall;

  // Unwritten cells read as ones
  function automatic logic [15:0] stored(input logic [17:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction : stored

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Output word and drive mask from the enables
  always @*
  begin
    word_v = id_hv ? (address_lines[0] ? DEV_CODE : MFR_CODE) : stored(address_lines);
    out_v  = word_v;
    en_v   = (!oe_n && (!ce_n || vpp_en)) ? 16'hffff : 16'h0000;
    if (!byte_n && !vpp_en)
    begin
      out_v = {8'h00, host_word[15] ? word_v[15:8] : word_v[7:0]};
      en_v  = en_v & 16'h00ff;
    end
  end

  // One delay, inside the page access time
  assign #DLY_NS out_d = out_v;
  assign #DLY_NS en_d  = en_v;

  initial
  begin
    q           = '0;
    en_p        = '0;
    contention  = 1'b0;
    id_addr_bad = 1'b0;
    pulse_ns    = 0;
  end

  // Released lines show the inverse of their last level
  always @(out_d or en_d)
  begin
    for (int i = 0; i < 16; i++)
      if (en_d[i]) q[i] = out_d[i];
      else if (en_p[i]) q[i] = ~q[i];
    en_p = en_d;
    if (!host_lo_oe_n && en_d[0]) contention = 1'b1;
    if (id_hv && en_d[0] && ({address_lines[17:10], address_lines[8:1]} != 16'h0000)) id_addr_bad = 1'b1;
  end

  // ****************************************************************
  // Programming
  // ****************************************************************
  // Pulse only on a low chip select with supply up and outputs off
  always @(negedge ce_n) if (vpp_en && oe_n) t_fall = $time;
  always @(posedge ce_n)
  begin
    if (vpp_en && oe_n)
    begin
      pulse_ns = int'($time - t_fall);
      npulse[int'(address_lines)] = npulse.exists(int'(address_lines)) ? npulse[int'(address_lines)] + 1 : 1;
      mem[int'(address_lines)] = stored(address_lines)
        & (host_word | ((address_lines == STUCK_ADDR) ? 16'h0001 : 16'h0000));
    end
  end
endmodule : pea_eprom_model

// [test/page_mode_eprom_access_bench.sv]
// Self-checking bench for the page-mode EPROM host controller
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module page_mode_eprom_access_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                        clk, rst, cmd_valid, cmd_ready, data_req, rsp_valid, rsp_ok;
  pea_pkg::pea_op_t            cmd_op;
  logic [pea_pkg::BADDR_W-1:0] cmd_addr;
  logic [pea_pkg::ADDR_W-1:0]  cmd_end, data_req_addr, rsp_fail_addr, address_lines;
  logic [pea_pkg::DATA_W-1:0]  wdata, rsp_data, q;
  logic                        ce_n, oe_n, byte_n, vpp_en, id_high_voltage_en, data_lines_oe_n;
  logic [pea_pkg::LOW_W-1:0]   data_lines_o, data_lines_i;
  logic                        top_data_or_byte_select_o, top_data_or_byte_select_oe_n, top_data_or_byte_select_i;
  logic [15:0]                 prog_val [int];
  int                          errors, samples_checked;

  pea_host #(.PROG_PULSE_CYC(20), .MAX_PULSES(25)) pea_host_i (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_end, .data_req, .data_req_addr, .wdata, .rsp_valid, .rsp_data, .rsp_ok, .rsp_fail_addr,
    .address_lines, .ce_n, .oe_n, .byte_n, .vpp_en, .id_high_voltage_en, .data_lines_o, .data_lines_oe_n,
    .data_lines_i, .top_data_or_byte_select_o, .top_data_or_byte_select_oe_n, .top_data_or_byte_select_i);

  pea_eprom_model pea_eprom_model_i (.address_lines, .ce_n, .oe_n, .byte_n, .vpp_en, .id_hv(id_high_voltage_en),
    .host_word({top_data_or_byte_select_o, data_lines_o}), .host_lo_oe_n(data_lines_oe_n), .q,
    .contention(), .id_addr_bad(), .pulse_ns());

  // Wire level of the shared data pins
  assign data_lines_i              = data_lines_oe_n ? q[14:0] : data_lines_o;
  assign top_data_or_byte_select_i = top_data_or_byte_select_oe_n ? q[15] : top_data_or_byte_select_o;

  // Program word handed over half a cycle after each request rises
  always @(negedge clk)
    if (data_req === 1'b1 && prog_val.exists(int'(data_req_addr))) wdata <= prog_val[int'(data_req_addr)];

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // One command, counting cycles from the take edge to the answer
  task automatic run_cmd(input pea_pkg::pea_op_t op, input logic [18:0] a, input logic [17:0] e, output int lat);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    cmd_op    = op;
    cmd_addr  = a;
    cmd_end   = e;
    cmd_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    lat       = 0;
    while (rsp_valid !== 1'b1 && lat < 20000)
    begin
      @(negedge clk);
      lat++;
    end
    if (n >= 100 || lat >= 20000)
    begin
      errors++;
      finish_test();
    end
  endtask : run_cmd

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    `CHECK("reset ce_n", 1'b1, ce_n)
    `CHECK("reset vpp_en", 1'b0, vpp_en)
    rst = 1'b0;
    @(negedge clk);
    `CHECK("cmd_ready", 1'b1, cmd_ready)
  endtask : t_reset

  // Full access, page hit at the page end, miss across the boundary
  task automatic t_read_word();
    int lat;
    pea_eprom_model_i.mem[32'h123] = 16'h5a3c;
    run_cmd(pea_pkg::OP_READ_WORD, 19'h00123, 18'h0, lat);
    `CHECK("word", 16'h5a3c, rsp_data)
    `CHECK("read ok", 1'b1, rsp_ok)
    `CHECK("read oe", 1'b0, oe_n)
    `CHECK("full lat", 21, lat)
    run_cmd(pea_pkg::OP_READ_WORD, 19'h00127, 18'h0, lat);
    `CHECK("erased", 16'hffff, rsp_data)
    `CHECK("hit lat", 12, lat)
    `CHECK("ce held", 1'b0, ce_n)
    run_cmd(pea_pkg::OP_READ_WORD, 19'h00128, 18'h0, lat);
    `CHECK("miss lat", 21, lat)
  endtask : t_read_word

  task automatic t_read_byte();
    int lat;
    run_cmd(pea_pkg::OP_READ_BYTE, 19'h00247, 18'h0, lat);
    `CHECK("upper byte", 16'h005a, rsp_data)
    `CHECK("byte sel driven", 1'b0, top_data_or_byte_select_oe_n)
    `CHECK("byte width", 1'b0, byte_n)
    run_cmd(pea_pkg::OP_READ_BYTE, 19'h00246, 18'h0, lat);
    `CHECK("lower byte", 16'h003c, rsp_data)
    `CHECK("byte hit lat", 12, lat)
  endtask : t_read_byte

  task automatic t_read_id();
    int lat;
    run_cmd(pea_pkg::OP_READ_ID, 19'h00000, 18'h0, lat);
    `CHECK("maker code", pea_eprom_model_i.MFR_CODE, rsp_data)
    `CHECK("maker parity", 1'b1, rsp_ok)
    run_cmd(pea_pkg::OP_READ_ID, 19'h00001, 18'h0, lat);
    `CHECK("part code", pea_eprom_model_i.DEV_CODE, rsp_data)
    `CHECK("part parity", 1'b1, rsp_ok)
    `CHECK("id address", 1'b0, pea_eprom_model_i.id_addr_bad)
    `CHECK("id lines", 18'h00001, address_lines)
    `CHECK("id voltage", 1'b1, id_high_voltage_en)
  endtask : t_read_id

  // Three words, the middle one never verifies
  task automatic t_program();
    int lat;
    prog_val[32'h200] = 16'h8421;
    prog_val[32'h201] = 16'h1230;
    prog_val[32'h202] = 16'h0000;
    run_cmd(pea_pkg::OP_PROGRAM, 19'h00200, 18'h00202, lat);
    `CHECK("word 200", 16'h8421, pea_eprom_model_i.mem[32'h200])
    `CHECK("word 202", 16'h0000, pea_eprom_model_i.mem[32'h202])
    `CHECK("pulses 200", 1, pea_eprom_model_i.npulse[32'h200])
    `CHECK("pulses 201", 25, pea_eprom_model_i.npulse[32'h201])
    `CHECK("pulses 202", 1, pea_eprom_model_i.npulse[32'h202])
    `CHECK("pulse width", 160, pea_eprom_model_i.pulse_ns)
    `CHECK("run ok", 1'b0, rsp_ok)
    `CHECK("fail addr", 18'h00201, rsp_fail_addr)
    `CHECK("supply off", 1'b0, vpp_en)
    `CHECK("standby", 1'b1, ce_n)
    `CHECK("outputs off", 1'b1, oe_n)
    `CHECK("last request", 18'h00202, data_req_addr)
  endtask : t_program

  initial
  begin
    errors          = 0;
    samples_checked = 0;
    rst             = 1'b1;
    cmd_valid       = 1'b0;
    cmd_op          = pea_pkg::OP_READ_WORD;
    cmd_addr        = '0;
    cmd_end         = '0;
    wdata           = '0;
    repeat (16) @(negedge clk);
    t_reset();
    t_read_word();
    t_read_byte();
    t_read_id();
    t_program();
    `CHECK("contention", 1'b0, pea_eprom_model_i.contention)
    finish_test();
  end
endmodule : page_mode_eprom_access_bench
